/* tmr_pkg.sv */
package tmr_pkg;

	////////////////////////////////////////////////////////////////////////
	// register addresses on the special function register bus
	localparam logic [7:0] ADDR_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_MODE = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
	localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
	localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
	localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RESET_CONTROL = 8'h00;
	localparam logic [7:0] RESET_MODE = 8'h00;
	localparam logic [7:0] RESET_COUNT = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// control register bit positions
	localparam int T1_OVERFLOW_FLAG = 7;
	localparam int T1_RUN_BIT = 6;
	localparam int T0_OVERFLOW_FLAG = 5;
	localparam int T0_RUN_BIT = 4;
	localparam int EXT_IRQ1_REQUEST_FLAG = 3;
	localparam int EXT_IRQ1_TRIGGER_TYPE = 2;
	localparam int EXT_IRQ0_REQUEST_FLAG = 1;
	localparam int EXT_IRQ0_TRIGGER_TYPE = 0;

	////////////////////////////////////////////////////////////////////////
	// mode register field positions
	localparam int T1_GATE = 7;
	localparam int T1_COUNTER_SEL = 6;
	localparam int T1_MODE_HI = 5;
	localparam int T1_MODE_LO = 4;
	localparam int T0_GATE = 3;
	localparam int T0_COUNTER_SEL = 2;
	localparam int T0_MODE_HI = 1;
	localparam int T0_MODE_LO = 0;

	////////////////////////////////////////////////////////////////////////
	// count limits
	localparam logic [4:0] PRESCALE_MAX = 5'h1f;
	localparam logic [4:0] PRESCALE_ONE = 5'h01;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [15:0] WORD_MAX = 16'hffff;
	localparam logic [15:0] WORD_ONE = 16'h0001;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		MODE_13BIT = 2'b00,
		MODE_16BIT = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_SPLIT = 2'b11
	} tmr_mode_t;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic ovf;
	} tmr_cnt_t;

	typedef struct packed {
		logic ext_irq1_pin;
		logic ext_irq0_pin;
		logic t1_count_pin;
		logic t0_count_pin;
	} tmr_pins_t;

	typedef struct packed {
		logic ext1;
		logic t1;
		logic ext0;
		logic t0;
	} tmr_ack_t;

endpackage : tmr_pkg

/* tmr_timer01_ctrl.sv */
// What this block does
// - timer 1 overflow sets control bit 7 in hardware; in split mode the timer 0 high byte sets it instead.
// - timer 0 overflow sets control bit 5 in hardware.
// - overflow flags clear when the core vectors to their service routine.
// - timer 1 counts only while run bit 6 is one.
// - timer 0 counts only while run bit 4 is one; in split mode its high byte counts while run bit 6 is one.
// - trigger-type bits 2 and 0 pick falling edge when set, low level when clear.
// - external request 1 flag, bit 3, set by edge or low level.
// - external request 0 flag, bit 1, set by edge or low level.
// - vectoring clears an external request flag only in edge mode.
// - in level mode the request flag follows the pin.
// - low four control bits do not affect the timers.
// - each timer is a high and a low byte, separately accessible.
// - mode decides separate bytes or one cascaded 16-bit counter.
// - all four count bytes are zero after reset.
// - both timers share the same mode behaviour, except mode 11, which stops timer 1.
// - timer mode counts every core clock, no divide-by-twelve.
// - mode 00 13-bit, 01 16-bit, 10 auto-reload, 11 split.
// - mode 0 uses high byte and low five bits of low byte.
// - counting needs run bit and either gate clear or interrupt pin high; the split-mode timer 0 high byte needs run bit 6 only.
`timescale 1ns/1ps
module tmr_timer01_ctrl (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire tmr_pkg::tmr_pins_t pins,
	input wire tmr_pkg::tmr_ack_t vector_ack,
	output logic [7:0] timer_and_ext_int_control
);

	////////////////////////////////////////////////////////////////////////
	// shared functions

	// one step of a timer in any mode; split mode steps the low byte only
	function automatic tmr_pkg::tmr_cnt_t tmr_step(
		input logic [1:0] mode,
		input logic [7:0] low,
		input logic [7:0] high,
		input logic inc
	);
		tmr_pkg::tmr_cnt_t r;
		r.low = low;
		r.high = high;
		r.ovf = 1'b0;
		if (inc) begin
			case (tmr_pkg::tmr_mode_t'(mode))
				tmr_pkg::MODE_13BIT: begin
					if (low[4:0] == tmr_pkg::PRESCALE_MAX) begin
						r.low = {low[7:5], 5'h00};
						r.high = high + tmr_pkg::BYTE_ONE;
						r.ovf = (high == tmr_pkg::BYTE_MAX);
					end else begin
						r.low = {low[7:5], low[4:0] + tmr_pkg::PRESCALE_ONE};
					end
				end
				tmr_pkg::MODE_16BIT: begin
					{r.high, r.low} = {high, low} + tmr_pkg::WORD_ONE;
					r.ovf = ({high, low} == tmr_pkg::WORD_MAX);
				end
				tmr_pkg::MODE_RELOAD: begin
					if (low == tmr_pkg::BYTE_MAX) begin
						r.low = high;
						r.ovf = 1'b1;
					end else begin
						r.low = low + tmr_pkg::BYTE_ONE;
					end
				end
				default: begin
					r.low = low + tmr_pkg::BYTE_ONE;
					r.ovf = (low == tmr_pkg::BYTE_MAX);
				end
			endcase
		end
		return r;
	endfunction : tmr_step

	// flag update: hardware set wins over any clear
	function automatic logic tmr_flag(
		input logic cur,
		input logic set,
		input logic wr,
		input logic wbit,
		input logic ack
	);
		return set | (wr ? wbit : (cur & ~ack));
	endfunction : tmr_flag

	function automatic logic tmr_hit(
		input logic [7:0] addr,
		input logic [7:0] reg_addr
	);
		return addr == reg_addr;
	endfunction : tmr_hit

	////////////////////////////////////////////////////////////////////////
	// state

	logic [7:0] timer_mode_register;
	logic [7:0] timer0_count_low;
	logic [7:0] timer0_count_high;
	logic [7:0] timer1_count_low;
	logic [7:0] timer1_count_high;
	tmr_pkg::tmr_pins_t pins_prev;

	////////////////////////////////////////////////////////////////////////
	// decode

	logic wr_control;
	logic wr_mode;
	logic wr_t0_low;
	logic wr_t0_high;
	logic wr_t1_low;
	logic wr_t1_high;

	assign wr_control = sfr_wr && tmr_hit(sfr_addr, tmr_pkg::ADDR_CONTROL);
	assign wr_mode = sfr_wr && tmr_hit(sfr_addr, tmr_pkg::ADDR_MODE);
	assign wr_t0_low = sfr_wr && tmr_hit(sfr_addr, tmr_pkg::ADDR_T0_LOW);
	assign wr_t0_high = sfr_wr && tmr_hit(sfr_addr, tmr_pkg::ADDR_T0_HIGH);
	assign wr_t1_low = sfr_wr && tmr_hit(sfr_addr, tmr_pkg::ADDR_T1_LOW);
	assign wr_t1_high = sfr_wr && tmr_hit(sfr_addr, tmr_pkg::ADDR_T1_HIGH);

	////////////////////////////////////////////////////////////////////////
	// field views

	logic t1_run_bit;
	logic t0_run_bit;
	logic ext_irq1_trigger_type;
	logic ext_irq0_trigger_type;
	logic [1:0] mode0;
	logic [1:0] mode1;
	logic gate0;
	logic gate1;
	logic counter_sel0;
	logic counter_sel1;

	assign t1_run_bit = timer_and_ext_int_control[tmr_pkg::T1_RUN_BIT];
	assign t0_run_bit = timer_and_ext_int_control[tmr_pkg::T0_RUN_BIT];
	assign ext_irq1_trigger_type = timer_and_ext_int_control[tmr_pkg::EXT_IRQ1_TRIGGER_TYPE];
	assign ext_irq0_trigger_type = timer_and_ext_int_control[tmr_pkg::EXT_IRQ0_TRIGGER_TYPE];
	assign mode0 = timer_mode_register[tmr_pkg::T0_MODE_HI:tmr_pkg::T0_MODE_LO];
	assign mode1 = timer_mode_register[tmr_pkg::T1_MODE_HI:tmr_pkg::T1_MODE_LO];
	assign gate0 = timer_mode_register[tmr_pkg::T0_GATE];
	assign gate1 = timer_mode_register[tmr_pkg::T1_GATE];
	assign counter_sel0 = timer_mode_register[tmr_pkg::T0_COUNTER_SEL];
	assign counter_sel1 = timer_mode_register[tmr_pkg::T1_COUNTER_SEL];

	////////////////////////////////////////////////////////////////////////
	// count enables

	logic t0_src;
	logic t1_src;
	logic t0_inc;
	logic t1_inc;
	logic split0;
	logic th0_split_inc;
	logic ext1_fall;
	logic ext0_fall;

	// timer source is every clock; counter source is a falling edge on the pin
	assign t0_src = counter_sel0 ? (pins_prev.t0_count_pin & ~pins.t0_count_pin) : 1'b1;
	assign t1_src = counter_sel1 ? (pins_prev.t1_count_pin & ~pins.t1_count_pin) : 1'b1;
	// only the run bits of the control register reach the timers
	assign t0_inc = t0_run_bit & (~gate0 | pins.ext_irq0_pin) & t0_src;
	assign t1_inc = t1_run_bit & (~gate1 | pins.ext_irq1_pin) & t1_src
		& (mode1 != tmr_pkg::MODE_SPLIT);
	assign split0 = (mode0 == tmr_pkg::MODE_SPLIT);
	assign th0_split_inc = split0 & t1_run_bit;
	assign ext1_fall = pins_prev.ext_irq1_pin & ~pins.ext_irq1_pin;
	assign ext0_fall = pins_prev.ext_irq0_pin & ~pins.ext_irq0_pin;

	tmr_pkg::tmr_cnt_t step0;
	tmr_pkg::tmr_cnt_t step1;
	logic [7:0] next_th0;
	logic t0_ovf_evt;
	logic t1_ovf_evt;

	assign step0 = tmr_step(mode0, timer0_count_low, timer0_count_high, t0_inc);
	assign step1 = tmr_step(mode1, timer1_count_low, timer1_count_high, t1_inc);
	assign next_th0 = split0 ? (th0_split_inc ? timer0_count_high + tmr_pkg::BYTE_ONE : timer0_count_high)
		: step0.high;
	assign t0_ovf_evt = step0.ovf;
	// in split mode the timer 0 high byte owns the timer 1 flag
	assign t1_ovf_evt = split0 ? (th0_split_inc & (timer0_count_high == tmr_pkg::BYTE_MAX)) : step1.ovf;

	////////////////////////////////////////////////////////////////////////
	// pin history

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pins_prev <= '1;
		end else begin
			pins_prev <= pins;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode register

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			timer_mode_register <= tmr_pkg::RESET_MODE;
		end else if (wr_mode) begin
			timer_mode_register <= sfr_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// count registers, software write wins over counting

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			timer0_count_low <= tmr_pkg::RESET_COUNT;
			timer0_count_high <= tmr_pkg::RESET_COUNT;
		end else begin
			timer0_count_low <= wr_t0_low ? sfr_wdata : step0.low;
			timer0_count_high <= wr_t0_high ? sfr_wdata : next_th0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			timer1_count_low <= tmr_pkg::RESET_COUNT;
			timer1_count_high <= tmr_pkg::RESET_COUNT;
		end else begin
			timer1_count_low <= wr_t1_low ? sfr_wdata : step1.low;
			timer1_count_high <= wr_t1_high ? sfr_wdata : step1.high;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register

	logic [7:0] next_control;

	always_comb begin
		next_control = timer_and_ext_int_control;
		next_control[tmr_pkg::T1_OVERFLOW_FLAG] = tmr_flag(timer_and_ext_int_control[tmr_pkg::T1_OVERFLOW_FLAG],
			t1_ovf_evt, wr_control, sfr_wdata[tmr_pkg::T1_OVERFLOW_FLAG], vector_ack.t1);
		next_control[tmr_pkg::T0_OVERFLOW_FLAG] = tmr_flag(timer_and_ext_int_control[tmr_pkg::T0_OVERFLOW_FLAG],
			t0_ovf_evt, wr_control, sfr_wdata[tmr_pkg::T0_OVERFLOW_FLAG], vector_ack.t0);
		if (wr_control) begin
			next_control[tmr_pkg::T1_RUN_BIT] = sfr_wdata[tmr_pkg::T1_RUN_BIT];
			next_control[tmr_pkg::T0_RUN_BIT] = sfr_wdata[tmr_pkg::T0_RUN_BIT];
			next_control[tmr_pkg::EXT_IRQ1_TRIGGER_TYPE] = sfr_wdata[tmr_pkg::EXT_IRQ1_TRIGGER_TYPE];
			next_control[tmr_pkg::EXT_IRQ0_TRIGGER_TYPE] = sfr_wdata[tmr_pkg::EXT_IRQ0_TRIGGER_TYPE];
		end
		// edge mode latches a fall, level mode mirrors the pin
		if (ext_irq1_trigger_type) begin
			next_control[tmr_pkg::EXT_IRQ1_REQUEST_FLAG] = tmr_flag(
				timer_and_ext_int_control[tmr_pkg::EXT_IRQ1_REQUEST_FLAG], ext1_fall, wr_control,
				sfr_wdata[tmr_pkg::EXT_IRQ1_REQUEST_FLAG], vector_ack.ext1);
		end else begin
			next_control[tmr_pkg::EXT_IRQ1_REQUEST_FLAG] = ~pins.ext_irq1_pin;
		end
		if (ext_irq0_trigger_type) begin
			next_control[tmr_pkg::EXT_IRQ0_REQUEST_FLAG] = tmr_flag(
				timer_and_ext_int_control[tmr_pkg::EXT_IRQ0_REQUEST_FLAG], ext0_fall, wr_control,
				sfr_wdata[tmr_pkg::EXT_IRQ0_REQUEST_FLAG], vector_ack.ext0);
		end else begin
			next_control[tmr_pkg::EXT_IRQ0_REQUEST_FLAG] = ~pins.ext_irq0_pin;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			timer_and_ext_int_control <= tmr_pkg::RESET_CONTROL;
		end else begin
			timer_and_ext_int_control <= next_control;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sfr_rdata <= tmr_pkg::READ_UNMAPPED;
		end else if (sfr_rd) begin
			case (sfr_addr)
				tmr_pkg::ADDR_CONTROL: sfr_rdata <= timer_and_ext_int_control;
				tmr_pkg::ADDR_MODE: sfr_rdata <= timer_mode_register;
				tmr_pkg::ADDR_T0_LOW: sfr_rdata <= timer0_count_low;
				tmr_pkg::ADDR_T0_HIGH: sfr_rdata <= timer0_count_high;
				tmr_pkg::ADDR_T1_LOW: sfr_rdata <= timer1_count_low;
				tmr_pkg::ADDR_T1_HIGH: sfr_rdata <= timer1_count_high;
				default: sfr_rdata <= tmr_pkg::READ_UNMAPPED;
			endcase
		end else begin
			sfr_rdata <= tmr_pkg::READ_UNMAPPED;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	a_t1_overflow_set: assert property (
		t1_ovf_evt |=> timer_and_ext_int_control[tmr_pkg::T1_OVERFLOW_FLAG])
		else $error("timer 1 overflow did not set its flag");

	a_t0_overflow_set: assert property (
		mode0 == tmr_pkg::MODE_16BIT && t0_inc && timer0_count_low == tmr_pkg::BYTE_MAX
		&& timer0_count_high == tmr_pkg::BYTE_MAX && !wr_t0_low && !wr_t0_high
		|=> timer_and_ext_int_control[tmr_pkg::T0_OVERFLOW_FLAG] && timer0_count_low == 8'h00
		&& timer0_count_high == 8'h00)
		else $error("timer 0 wrap did not set its flag");

	a_overflow_ack_clear: assert property (
		vector_ack.t0 && !t0_ovf_evt && !wr_control |=> !timer_and_ext_int_control[tmr_pkg::T0_OVERFLOW_FLAG])
		else $error("vector did not clear timer 0 flag");

	a_t1_stopped_hold: assert property (
		!t1_run_bit && !split0 && !wr_t1_low && !wr_t1_high
		|=> $stable(timer1_count_low) && $stable(timer1_count_high))
		else $error("timer 1 moved while stopped");

	a_t0_stopped_hold: assert property (
		!t0_run_bit && !split0 && !wr_t0_low && !wr_t0_high
		|=> $stable(timer0_count_low) && $stable(timer0_count_high))
		else $error("timer 0 moved while stopped");

	a_edge_request_set: assert property (
		ext_irq0_trigger_type && pins_prev.ext_irq0_pin && !pins.ext_irq0_pin
		|=> timer_and_ext_int_control[tmr_pkg::EXT_IRQ0_REQUEST_FLAG])
		else $error("falling edge did not set request 0");

	a_edge_ack_clear: assert property (
		ext_irq1_trigger_type && vector_ack.ext1 && !ext1_fall && !wr_control
		|=> !timer_and_ext_int_control[tmr_pkg::EXT_IRQ1_REQUEST_FLAG])
		else $error("vector did not clear edge request 1");

	a_level_follow_pin: assert property (
		!ext_irq1_trigger_type
		|=> timer_and_ext_int_control[tmr_pkg::EXT_IRQ1_REQUEST_FLAG] == !$past(pins.ext_irq1_pin))
		else $error("level request 1 does not follow pin");

	a_timer_clock_rate: assert property (
		mode0 == tmr_pkg::MODE_16BIT && t0_run_bit && !gate0 && !counter_sel0 && !wr_t0_low && !wr_t0_high
		|=> {timer0_count_high, timer0_count_low} == $past({timer0_count_high, timer0_count_low}) + tmr_pkg::WORD_ONE)
		else $error("timer did not advance each clock");

	a_gate_blocks_count: assert property (
		gate0 && !pins.ext_irq0_pin && !split0 && !wr_t0_low && !wr_t0_high
		|=> $stable(timer0_count_low) && $stable(timer0_count_high))
		else $error("gated timer 0 counted with pin low");

	a_prescale_no_carry: assert property (
		mode0 == tmr_pkg::MODE_13BIT && t0_inc && timer0_count_low[4:0] != tmr_pkg::PRESCALE_MAX && !wr_t0_high
		|=> $stable(timer0_count_high))
		else $error("mode 0 high byte moved before prescale wrap");

endmodule : tmr_timer01_ctrl

/* tmr_core_model.sv */
`timescale 1ns/1ps
module tmr_core_model (
	input wire logic ref_clk,
	input wire logic [7:0] sfr_rdata,
	output logic [7:0] sfr_addr,
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_wdata,
	output tmr_pkg::tmr_ack_t vector_ack
);
	initial begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		vector_ack = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// one write strobe; address and data scrambled once released
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
		sfr_addr <= ~a;
		sfr_wdata <= ~d;
	endtask : write_reg

	// read strobe, data taken one cycle later
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		sfr_addr <= ~a;
		@(posedge ref_clk);
		d = sfr_rdata;
	endtask : read_reg

	// one-cycle vector acknowledge
	task automatic pulse_ack(input tmr_pkg::tmr_ack_t v);
		@(posedge ref_clk);
		vector_ack <= v;
		@(posedge ref_clk);
		vector_ack <= '0;
	endtask : pulse_ack
endmodule : tmr_core_model

/* tmr_timer01_ctrl_test.sv */
`timescale 1ns/1ps
module tmr_timer01_ctrl_test;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] sfr_addr;
	logic sfr_wr;
	logic sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic [7:0] ctrl;
	tmr_pkg::tmr_pins_t pins = 4'hf;
	tmr_pkg::tmr_ack_t vector_ack;
	logic [7:0] d;
	int err_count = 0;
	int checks_done = 0;

	always #2 ref_clk = ~ref_clk;

	tmr_timer01_ctrl u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pins(pins),
		.vector_ack(vector_ack), .timer_and_ext_int_control(ctrl));
	tmr_core_model u_core (.ref_clk(ref_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .vector_ack(vector_ack));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		u_core.read_reg(a, v);
		check(what, exp, v);
	endtask : rd_check

	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	// runs timer t for n cycles from hi:lo, then compares with an integer model
	task automatic run_case(input int t, input int m, input int hi, input int lo, input int n);
		int of;
		int v;
		int en;
		of = 0;
		u_core.write_reg(tmr_pkg::ADDR_CONTROL, 8'h00);
		// pin level taken after the caller's pin update has landed
		en = (m / 8 % 2 == 0) || (pins[2 + t] == 1'b1);
		u_core.write_reg(tmr_pkg::ADDR_MODE, 8'(m << (4 * t)));
		u_core.write_reg(tmr_pkg::ADDR_T0_HIGH + 8'(t), 8'(hi));
		u_core.write_reg(tmr_pkg::ADDR_T0_LOW + 8'(t), 8'(lo));
		u_core.write_reg(tmr_pkg::ADDR_CONTROL, (t == 1) ? 8'h40 : 8'h10);
		repeat (n - 2) @(posedge ref_clk);
		u_core.write_reg(tmr_pkg::ADDR_CONTROL, 8'h00);
		#1;
		for (int i = 0; i < (en ? n : 0); i++) begin
			case (m % 4)
				0: begin
					v = hi * 32 + lo % 32 + 1;
					of = (v == 8192);
					v = v % 8192;
					hi = v / 32;
					lo = lo - lo % 32 + v % 32;
				end
				1: begin
					v = hi * 256 + lo + 1;
					of = (v == 65536);
					hi = v % 65536 / 256;
					lo = v % 256;
				end
				2: begin
					lo = lo + 1;
					of = (lo == 256);
					if (of) lo = hi;
				end
				default: of = 0;
			endcase
		end
		check("overflow flag", 8'(of), 8'(ctrl[(t == 1) ? 7 : 5]));
		rd_check("count low", tmr_pkg::ADDR_T0_LOW + 8'(t), 8'(lo));
		rd_check("count high", tmr_pkg::ADDR_T0_HIGH + 8'(t), 8'(hi));
		u_core.pulse_ack((t == 1) ? 4'b0100 : 4'b0001);
		#1;
		check("flag after ack", 8'h00, 8'(ctrl[(t == 1) ? 7 : 5]));
	endtask : run_case

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(97));
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 7; a++) rd_check("reset value", 8'h88 + 8'(a), 8'h00);
		for (int a = 0; a < 4; a++) begin
			d = 8'($urandom % 256);
			u_core.write_reg(tmr_pkg::ADDR_T0_LOW + 8'(a), d);
			rd_check("count byte", tmr_pkg::ADDR_T0_LOW + 8'(a), d);
		end
		u_core.write_reg(8'h8e, 8'h5a);
		rd_check("unmapped", 8'h8e, 8'h00);
		for (int t = 0; t < 2; t++) begin
			run_case(t, 1, 255, 254, 2);
			run_case(t, 0, 255, 30, 2);
			run_case(t, 2, 90, 254, 2);
		end
		run_case(1, 3, 18, 52, 5);
		@(posedge ref_clk);
		pins[2] <= 1'b0;
		run_case(0, 9, 0, 0, 10);
		@(posedge ref_clk);
		pins[2] <= 1'b1;
		run_case(0, 9, 0, 0, 10);
		for (int r = 0; r < 12; r++) begin
			int t;
			t = $urandom % 2;
			@(posedge ref_clk);
			pins[2 + t] <= 1'($urandom % 2);
			run_case(t, ((t == 1) ? $urandom % 4 : $urandom % 3) + ($urandom % 2) * 8,
				$urandom % 256, $urandom % 256, 2 + $urandom % 200);
			@(posedge ref_clk);
			pins[2 + t] <= 1'b1;
		end
		// external request flags, edge then level mode
		for (int k = 0; k < 2; k++) begin
			u_core.write_reg(tmr_pkg::ADDR_CONTROL, (k == 1) ? 8'h04 : 8'h01);
			@(posedge ref_clk);
			pins[2 + k] <= 1'b0;
			@(posedge ref_clk);
			pins[2 + k] <= 1'b1;
			repeat (2) @(posedge ref_clk);
			#1;
			check("edge request", 8'h01, 8'(ctrl[2 * k + 1]));
			u_core.pulse_ack((k == 1) ? 4'b1000 : 4'b0010);
			#1;
			check("edge request acked", 8'h00, 8'(ctrl[2 * k + 1]));
			u_core.write_reg(tmr_pkg::ADDR_CONTROL, 8'h00);
			@(posedge ref_clk);
			pins[2 + k] <= 1'b0;
			repeat (2) @(posedge ref_clk);
			#1;
			check("level request", 8'h01, 8'(ctrl[2 * k + 1]));
			u_core.pulse_ack((k == 1) ? 4'b1000 : 4'b0010);
			#1;
			check("level request acked", 8'h01, 8'(ctrl[2 * k + 1]));
			@(posedge ref_clk);
			pins[2 + k] <= 1'b1;
			repeat (2) @(posedge ref_clk);
			#1;
			check("level released", 8'h00, 8'(ctrl[2 * k + 1]));
		end
		// low control nibble leaves both timers stopped
		u_core.write_reg(tmr_pkg::ADDR_MODE, 8'h11);
		u_core.write_reg(tmr_pkg::ADDR_T0_LOW, 8'h00);
		u_core.write_reg(tmr_pkg::ADDR_T1_LOW, 8'h00);
		u_core.write_reg(tmr_pkg::ADDR_CONTROL, 8'h0f);
		repeat (20) @(posedge ref_clk);
		rd_check("t0 idle", tmr_pkg::ADDR_T0_LOW, 8'h00);
		rd_check("t1 idle", tmr_pkg::ADDR_T1_LOW, 8'h00);
		// counter mode: each timer counts falling edges on its count pin
		u_core.write_reg(tmr_pkg::ADDR_MODE, 8'h55);
		u_core.write_reg(tmr_pkg::ADDR_T0_LOW, 8'h00);
		u_core.write_reg(tmr_pkg::ADDR_T1_LOW, 8'h00);
		u_core.write_reg(tmr_pkg::ADDR_CONTROL, 8'h50);
		for (int p = 0; p < 6; p++) begin
			@(posedge ref_clk);
			pins[p % 2] <= 1'b0;
			repeat (2) @(posedge ref_clk);
			pins[p % 2] <= 1'b1;
		end
		u_core.write_reg(tmr_pkg::ADDR_CONTROL, 8'h00);
		rd_check("t0 pin count", tmr_pkg::ADDR_T0_LOW, 8'h03);
		rd_check("t1 pin count", tmr_pkg::ADDR_T1_LOW, 8'h03);
		// split mode: timer 0 high byte runs on the timer 1 run bit and sets the timer 1 flag
		u_core.write_reg(tmr_pkg::ADDR_MODE, 8'h03);
		u_core.write_reg(tmr_pkg::ADDR_T0_LOW, 8'hfe);
		u_core.write_reg(tmr_pkg::ADDR_T0_HIGH, 8'hfe);
		u_core.write_reg(tmr_pkg::ADDR_CONTROL, 8'h50);
		u_core.write_reg(tmr_pkg::ADDR_CONTROL, 8'h00);
		#1;
		check("split flags", 8'ha0, ctrl);
		rd_check("split low", tmr_pkg::ADDR_T0_LOW, 8'h00);
		rd_check("split high", tmr_pkg::ADDR_T0_HIGH, 8'h00);
		conclude();
	end

	initial begin
		#80000;
		err_count++;
		conclude();
	end
endmodule : tmr_timer01_ctrl_test
